// file: common/hsp_consts.svh
// constants for the serial port timing and fifo status block
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH
// ****************************************
// register offsets on the processor port
// ****************************************
`define HSP_OFF_FIFO_STATE 4'h0
`define HSP_OFF_DATA 4'h1
`define HSP_OFF_CONTROL 4'h2
`define HSP_OFF_CC_TX 4'h3
`define HSP_OFF_TIMING 4'h4
`define HSP_OFF_CC_STATUS 4'h5
`define HSP_OFF_WATCHDOG 4'h6
// ****************************************
// field positions and reset values
// ****************************************
`define HSP_CTRL_FILL_LSB 2
`define HSP_FILL_TRANSPARENT 2'h2
`define HSP_TIM_IC_BIT 6
`define HSP_TIM_CONTROL_CHANNEL_ENABLE_BIT 5
`define HSP_TIM_RATE_BIT 4
`define HSP_CTRL_RESET 8'h00
`define HSP_TIM_RESET 8'h00
`define HSP_IDLE_BYTE 8'hFF
`define HSP_WD_PATTERN 5'h0A
`define HSP_TC_ONE_BIT 4'hF
// ****************************************
// frame layout, thresholds, status delays
// ****************************************
`define HSP_CC_CHANNEL 5'h01
`define HSP_FIFO_DEPTH 19
`define HSP_RX_HIGH 15
`define HSP_TX_LOW 5
`define HSP_DLY_SHORT 3'h2
`define HSP_DLY_LONG 3'h4
`endif

// file: common/hsp_pkg.sv
// types shared by the serial port timing block
package hsp_pkg;
  // configuration carried from the register side to the link side
  typedef struct packed {
    logic ic;
    logic control_channel_enable;
    logic rate_2m;
    logic [3:0] tc;
    logic xparent;
    logic [7:0] cc_tx;
  } hsp_cfg_t;

  // one processor port access
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hsp_req_t;

  typedef enum logic [1:0] {
    HSP_FILL_IDLE,
    HSP_FILL_FLAGS,
    HSP_FILL_XPARENT,
    HSP_FILL_GO_AHEAD
  } hsp_fill_t;
endpackage

// file: logic/hsp_serial_port.sv
// serial port timing, transparent transfer, watchdog and fifo status
// Summary of operation
// [RULE_01] internal mode uses frame pulse, reserves channel one
// [RULE_02] rate select: 0 is 4.096 MHz, 1 is 2.048
// [RULE_03] data only in timeslots chosen by timeslot bits
// [RULE_04] internal mode ignores external clock enables
// [RULE_05] control byte sent in channel one when enabled
// [RULE_06] channel one input always captured to status
// [RULE_07] external mode shifts while active-low enable asserted
// [RULE_08] external: launch on rising, sample on falling
// [RULE_09] enable changes act at bit boundaries only
// [RULE_10] transparent mode moves bytes through 19-byte fifos
// [RULE_11] short slots send only low bits of byte
// [RULE_12] short slots receive into high bits of byte
// [RULE_13] empty transmit fifo repeats last byte written
// [RULE_14] fifo status keeps meaning in transparent mode
// [RULE_15] eleven-stage watchdog on frame pulse, clearable
// [RULE_16] watchdog low for 1024 pulses after 1024 unserviced
// [RULE_17] bit zero sent first, first received to bit zero
// [RULE_18] status 7:6 next byte kind, 1:0 low
// [RULE_19] status 5:4 encode receive fifo fill
// [RULE_20] receive status update delayed by clock edges
// [RULE_21] status 3:2 encode transmit fifo fill
// [RULE_22] transmit status delayed same way as receive
`include "hsp_consts.svh"
module hsp_serial_port #(
  parameter int DEPTH = `HSP_FIFO_DEPTH
) (
  // system side
  input wire logic clk,
  input wire logic resetn,
  // processor port
  input wire hsp_pkg::hsp_req_t req,
  output logic [7:0] rdata,
  // link side
  input wire logic serial_clock_in,
  input wire logic frame_pulse_in,
  input wire logic transmit_clock_enable_n,
  input wire logic receive_clock_enable_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  output logic watchdog_out_n
);
  import hsp_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // ****************************************
  // register side
  // ****************************************
  logic [7:0] ctrl_reg, tim_reg, cc_tx_reg, cc_stat_reg, rdata_reg, fifo_shown_reg;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;
  logic [7:0] tx_xfer_reg;
  logic ack_tog_reg, wd_tog_reg;
  logic [2:0] wait_reg;
  // crossings into clk: req, rx byte, control byte, falling edge toggles
  logic [2:0] req_s_reg, rxt_s_reg, cct_s_reg, neg_s_reg;
  // link side state, declared here because the register side reads it
  hsp_cfg_t cfg_s1_reg, cfg_reg;
  logic lrst_s1_reg, lrst_n_reg;
  logic [1:0] txe_s_reg, rxe_s_reg, ack_s_reg, wd_s_reg, fp_s_reg;
  logic ack_d_reg, wd_d_reg, fp_d_reg, phase_reg;
  logic [7:0] pos_reg, tx_cur_reg, tx_next_reg, rx_sr_reg, rx_xfer_reg, cc_sr_reg, cc_link_reg;
  logic [2:0] tx_bit_reg, rx_bit_reg;
  logic req_tog_reg, rx_tog_reg, cc_tog_reg, neg_tog_reg, rx_samp_reg;
  logic sdo_reg, sdo_en_reg;
  logic [10:0] wd_cnt_reg;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire hsp_fill_t fill = hsp_fill_t'(ctrl_reg[`HSP_CTRL_FILL_LSB +: 2]);
  wire wr_data = req.wr && req.addr == `HSP_OFF_DATA;
  wire rd_data = req.rd && req.addr == `HSP_OFF_DATA;
  wire wr_wd = req.wr && req.addr == `HSP_OFF_WATCHDOG && req.wdata[4:0] == `HSP_WD_PATTERN;
  wire tx_push = wr_data && tx_cnt_reg != CW'(DEPTH);
  wire tx_pop = (req_s_reg[2] ^ req_s_reg[1]) && tx_cnt_reg != '0;
  wire rx_push = (rxt_s_reg[2] ^ rxt_s_reg[1]) && rx_cnt_reg != CW'(DEPTH);
  wire rx_pop = rd_data && rx_cnt_reg != '0;
  wire neg_edge = neg_s_reg[2] ^ neg_s_reg[1];
  wire access = tx_push || tx_pop || rx_push || rx_pop;
  // one bit per frame in internal mode cannot carry bytes
  wire xparent = fill == HSP_FILL_XPARENT
    && !(tim_reg[`HSP_TIM_IC_BIT] && tim_reg[3:0] == `HSP_TC_ONE_BIT); // RULE_10
  // 4.096 MHz internal clock counts four edges, all others two
  wire [2:0] delay = (tim_reg[`HSP_TIM_IC_BIT] && !tim_reg[`HSP_TIM_RATE_BIT])
    ? `HSP_DLY_LONG : `HSP_DLY_SHORT; // RULE_20 RULE_22
  wire [1:0] rx_code = (rx_cnt_reg == '0) ? 2'h0 :
    (rx_cnt_reg == CW'(DEPTH)) ? 2'h2 :
    (rx_cnt_reg >= CW'(`HSP_RX_HIGH)) ? 2'h3 : 2'h1; // RULE_19
  wire [1:0] tx_code = (tx_cnt_reg == CW'(DEPTH)) ? 2'h0 :
    (tx_cnt_reg == '0) ? 2'h2 :
    (tx_cnt_reg >= CW'(`HSP_TX_LOW)) ? 2'h1 : 2'h3; // RULE_21
  // only transparent bytes enter here, so every byte is a packet byte
  wire [7:0] status_live = {2'h0, rx_code, tx_code, 2'h0}; // RULE_18 RULE_14
  wire [7:0] rd_mux =
    (req.addr == `HSP_OFF_FIFO_STATE) ? fifo_shown_reg :
    (req.addr == `HSP_OFF_DATA) ? rx_mem[rx_rp_reg] :
    (req.addr == `HSP_OFF_CONTROL) ? ctrl_reg :
    (req.addr == `HSP_OFF_CC_TX) ? cc_tx_reg :
    (req.addr == `HSP_OFF_TIMING) ? tim_reg :
    (req.addr == `HSP_OFF_CC_STATUS) ? cc_stat_reg : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `HSP_CTRL_RESET;
      tim_reg <= `HSP_TIM_RESET;
      cc_tx_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      if (req.wr && req.addr == `HSP_OFF_CONTROL) ctrl_reg <= req.wdata;
      if (req.wr && req.addr == `HSP_OFF_TIMING) tim_reg <= req.wdata;
      if (req.wr && req.addr == `HSP_OFF_CC_TX) cc_tx_reg <= req.wdata;
      if (req.rd) rdata_reg <= rd_mux;
    end
  end

  // fifo storage needs no reset
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp_reg] <= req.wdata;
    if (rx_push) rx_mem[rx_wp_reg] <= rx_xfer_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      tx_xfer_reg <= `HSP_IDLE_BYTE;
      ack_tog_reg <= 1'b0;
    end else begin
      if (tx_push) tx_wp_reg <= ptr_inc(tx_wp_reg);
      if (rx_push) rx_wp_reg <= ptr_inc(rx_wp_reg);
      if (rx_pop) rx_rp_reg <= ptr_inc(rx_rp_reg);
      if (tx_pop) begin
        tx_rp_reg <= ptr_inc(tx_rp_reg);
        tx_xfer_reg <= tx_mem[tx_rp_reg];
        ack_tog_reg <= ~ack_tog_reg;
      end
      tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
      rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // status shown only after enough link falling edges since last access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 3'h0;
      fifo_shown_reg <= 8'h08;
    end else begin
      if (access) wait_reg <= delay; // RULE_20 RULE_22
      else if (neg_edge && wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h0 && !access) fifo_shown_reg <= status_live;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_s_reg <= 3'h0;
      rxt_s_reg <= 3'h0;
      cct_s_reg <= 3'h0;
      neg_s_reg <= 3'h0;
      cc_stat_reg <= 8'h00;
      wd_tog_reg <= 1'b0;
    end else begin
      req_s_reg <= {req_s_reg[1:0], req_tog_reg};
      rxt_s_reg <= {rxt_s_reg[1:0], rx_tog_reg};
      cct_s_reg <= {cct_s_reg[1:0], cc_tog_reg};
      neg_s_reg <= {neg_s_reg[1:0], neg_tog_reg};
      if (cct_s_reg[2] ^ cct_s_reg[1]) cc_stat_reg <= cc_link_reg; // RULE_06
      if (wr_wd) wd_tog_reg <= ~wd_tog_reg; // RULE_15
    end
  end

  assign rdata = rdata_reg;

  // ****************************************
  // link side, on the serial clock
  // ****************************************

  wire hsp_cfg_t cfg_next = '{ic: tim_reg[`HSP_TIM_IC_BIT], control_channel_enable: tim_reg[`HSP_TIM_CONTROL_CHANNEL_ENABLE_BIT],
    rate_2m: tim_reg[`HSP_TIM_RATE_BIT], tc: tim_reg[3:0], xparent: xparent, cc_tx: cc_tx_reg};
  wire fp_start = !fp_s_reg[1] && fp_d_reg;
  // at 4.096 MHz two clocks make one bit of the 2.048 Mbps stream
  wire bit_tick = !cfg_reg.ic || cfg_reg.rate_2m || phase_reg; // RULE_02
  wire [4:0] chan = pos_reg[7:3];
  wire [2:0] bidx = pos_reg[2:0];
  wire one_bit = cfg_reg.tc == `HSP_TC_ONE_BIT;
  wire [4:0] sel_chan = one_bit ? 5'h02 : 5'h02 + {3'h0, cfg_reg.tc[3:2]};
  wire [3:0] nbits = one_bit ? 4'h1 :
    (cfg_reg.tc[1:0] == 2'h0) ? 4'h8 : (cfg_reg.tc[1:0] == 2'h1) ? 4'h7 :
    (cfg_reg.tc[1:0] == 2'h2) ? 4'h6 : 4'h2;
  wire data_slot = cfg_reg.ic && chan == sel_chan && {1'b0, bidx} < nbits; // RULE_03
  wire cc_slot = cfg_reg.ic && chan == `HSP_CC_CHANNEL; // RULE_01
  // enables only matter outside internal mode
  wire tx_go = cfg_reg.ic ? (data_slot && bit_tick) : !txe_s_reg[1]; // RULE_04 RULE_07
  wire rx_go = cfg_reg.ic ? (data_slot && bit_tick) : !rxe_s_reg[1]; // RULE_04 RULE_07
  wire [2:0] last_bit = cfg_reg.ic ? 3'(nbits - 4'h1) : 3'h7;
  wire [7:0] rx_shifted = {rx_samp_reg, rx_sr_reg[7:1]};
  wire [7:0] cc_shifted = {rx_samp_reg, cc_sr_reg[7:1]};

  always_ff @(posedge serial_clock_in or negedge resetn) begin
    if (!resetn) begin
      lrst_s1_reg <= 1'b0;
      lrst_n_reg <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n_reg <= lrst_s1_reg;
    end
  end

  // configuration is static while running, so a plain level sync suffices
  always_ff @(posedge serial_clock_in or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      cfg_s1_reg <= '0;
      cfg_reg <= '0;
      {txe_s_reg, rxe_s_reg, fp_s_reg} <= 6'h3F;
      {ack_s_reg, wd_s_reg} <= 4'h0;
      {ack_d_reg, wd_d_reg, fp_d_reg} <= 3'h1;
    end else begin
      cfg_s1_reg <= cfg_next;
      cfg_reg <= cfg_s1_reg;
      txe_s_reg <= {txe_s_reg[0], transmit_clock_enable_n}; // RULE_09
      rxe_s_reg <= {rxe_s_reg[0], receive_clock_enable_n}; // RULE_09
      fp_s_reg <= {fp_s_reg[0], frame_pulse_in};
      ack_s_reg <= {ack_s_reg[0], ack_tog_reg};
      wd_s_reg <= {wd_s_reg[0], wd_tog_reg};
      ack_d_reg <= ack_s_reg[1];
      wd_d_reg <= wd_s_reg[1];
      fp_d_reg <= fp_s_reg[1];
    end
  end

  // input bits sampled on the falling edge
  always_ff @(negedge serial_clock_in or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      rx_samp_reg <= 1'b1;
      neg_tog_reg <= 1'b0;
    end else begin
      rx_samp_reg <= serial_data_in; // RULE_08
      neg_tog_reg <= ~neg_tog_reg;
    end
  end

  // frame position and transmit path
  always_ff @(posedge serial_clock_in or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      pos_reg <= 8'h00;
      phase_reg <= 1'b0;
      tx_cur_reg <= `HSP_IDLE_BYTE;
      tx_next_reg <= `HSP_IDLE_BYTE;
      tx_bit_reg <= 3'h0;
      req_tog_reg <= 1'b0;
      sdo_reg <= 1'b1;
      sdo_en_reg <= 1'b0;
    end else begin
      if (fp_start) begin
        pos_reg <= 8'h00;
        phase_reg <= 1'b0;
      end else begin
        phase_reg <= ~phase_reg;
        if (bit_tick) pos_reg <= pos_reg + 8'h01;
      end
      // holds the last byte delivered, so an empty fifo repeats it
      if (ack_s_reg[1] ^ ack_d_reg) tx_next_reg <= tx_xfer_reg; // RULE_13
      // every internal slot starts a fresh byte, whatever external mode left
      if (fp_start && cfg_reg.ic) tx_bit_reg <= 3'h0; // RULE_11
      else if (tx_go && cfg_reg.xparent) begin
        if (tx_bit_reg == last_bit) begin
          tx_bit_reg <= 3'h0;
          tx_cur_reg <= tx_next_reg;
          req_tog_reg <= ~req_tog_reg; // RULE_10
        end else begin
          tx_bit_reg <= tx_bit_reg + 3'h1;
        end
      end
      if (bit_tick) begin
        if (cc_slot && cfg_reg.control_channel_enable) sdo_reg <= cfg_reg.cc_tx[bidx]; // RULE_05
        else if (tx_go && cfg_reg.xparent) sdo_reg <= tx_cur_reg[tx_bit_reg]; // RULE_11 RULE_17
        else sdo_reg <= 1'b1;
        sdo_en_reg <= (cc_slot && cfg_reg.control_channel_enable) || tx_go; // RULE_08
      end
    end
  end

  // receive path and control channel capture
  always_ff @(posedge serial_clock_in or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      rx_sr_reg <= 8'h00;
      rx_xfer_reg <= 8'h00;
      rx_bit_reg <= 3'h0;
      rx_tog_reg <= 1'b0;
      cc_sr_reg <= 8'h00;
      cc_link_reg <= 8'h00;
      cc_tog_reg <= 1'b0;
    end else begin
      if (fp_start && cfg_reg.ic) rx_bit_reg <= 3'h0; // RULE_12
      else if (rx_go && cfg_reg.xparent) begin
        rx_sr_reg <= rx_shifted; // RULE_17
        if (rx_bit_reg == last_bit) begin
          rx_bit_reg <= 3'h0;
          rx_xfer_reg <= rx_shifted; // RULE_12
          rx_tog_reg <= ~rx_tog_reg; // RULE_10
        end else begin
          rx_bit_reg <= rx_bit_reg + 3'h1;
        end
      end
      if (cc_slot && bit_tick) begin
        cc_sr_reg <= cc_shifted;
        if (bidx == 3'h7) begin
          cc_link_reg <= cc_shifted; // RULE_06
          cc_tog_reg <= ~cc_tog_reg;
        end
      end
    end
  end

  // watchdog: the external reset or a processor clear write clears it, upper half of wrap is the alarm
  always_ff @(posedge serial_clock_in or negedge resetn) begin
    if (!resetn) wd_cnt_reg <= 11'h000;
    else if (wd_s_reg[1] ^ wd_d_reg) wd_cnt_reg <= 11'h000; // RULE_15
    else if (fp_start) wd_cnt_reg <= wd_cnt_reg + 11'h001; // RULE_15
  end

  assign watchdog_out_n = ~wd_cnt_reg[10]; // RULE_16
  assign serial_data_out = sdo_reg;
  assign serial_data_out_en = sdo_en_reg;

  // ****************************************
  // checks
  // ****************************************
  low_bits_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_18
    fifo_shown_reg[1:0] == 2'h0 && fifo_shown_reg[7:6] == 2'h0)
    else $error("fifo status low bits not zero");
  rx_empty_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_19
    (wait_reg == 3'h0 && !access && rx_cnt_reg == '0) |=> fifo_shown_reg[5:4] == 2'h0)
    else $error("rx empty not reported");
  tx_full_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_21
    (wait_reg == 3'h0 && !access && tx_cnt_reg == CW'(DEPTH)) |=> fifo_shown_reg[3:2] == 2'h0)
    else $error("tx full not reported");
  delay_load_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_20
    access |=> wait_reg == $past(delay))
    else $error("status delay not loaded");
  delay_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_22
    (wait_reg != 3'h0) |=> $stable(fifo_shown_reg))
    else $error("status changed during delay");
  tx_over_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
    (tx_cnt_reg == CW'(DEPTH) && !tx_pop) |=> tx_cnt_reg == CW'(DEPTH))
    else $error("tx fifo overfilled");
  wd_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
    wr_wd |=> wd_tog_reg != $past(wd_tog_reg))
    else $error("watchdog clear lost");
  wd_count_a: assert property (@(posedge serial_clock_in) disable iff (!lrst_n_reg) // RULE_16
    (fp_start && !(wd_s_reg[1] ^ wd_d_reg)) |=> wd_cnt_reg == $past(wd_cnt_reg) + 11'h001)
    else $error("watchdog missed frame pulse");
  slot_off_a: assert property (@(posedge serial_clock_in) disable iff (!lrst_n_reg) // RULE_03
    (bit_tick && cfg_reg.ic && !data_slot && !cc_slot) |=> !serial_data_out_en)
    else $error("driving outside selected slot");
  cc_out_a: assert property (@(posedge serial_clock_in) disable iff (!lrst_n_reg) // RULE_05
    (bit_tick && cc_slot && cfg_reg.control_channel_enable) |=> serial_data_out == $past(cfg_reg.cc_tx[bidx]))
    else $error("control byte bit wrong");
  rx_fill_c: cover property (@(posedge clk) disable iff (!resetn)
    rx_cnt_reg == CW'(DEPTH));
  tx_fill_c: cover property (@(posedge clk) disable iff (!resetn)
    tx_push ##[1:50] tx_pop);
  wd_alarm_c: cover property (@(posedge serial_clock_in) disable iff (!lrst_n_reg)
    $fell(watchdog_out_n));
endmodule

// file: tb/hsp_link_model.sv
// far-side line device model: link clock, frame pulses, enables and serial data
module hsp_link_model (
  // link pins driven by the far side
  output logic serial_clock_in,
  output logic frame_pulse_in,
  output logic transmit_clock_enable_n,
  output logic receive_clock_enable_n,
  output logic serial_data_in,
  // link pins driven by the block
  input wire logic serial_data_out,
  input wire logic serial_data_out_en
);
  timeunit 1ns;
  timeprecision 100ps;
  int pcount = 0;
  int phase = 0;
  int nbit = 0;
  // link clocks per frame; the bench widens it for internal mode
  int frame_len = 4;
  logic [7:0] shreg;
  logic [7:0] cap_q[$];

  // odd start offset keeps the link clock out of phase with clk
  initial begin
    serial_clock_in = 1'h0;
    frame_pulse_in = 1'h1;
    transmit_clock_enable_n = 1'h1;
    receive_clock_enable_n = 1'h1;
    serial_data_in = 1'h1;
    #3.7;
    forever #16 serial_clock_in = ~serial_clock_in;
  end

  // short frames: data framing ignores them, only the watchdog counts them
  always @(posedge serial_clock_in) begin
    phase <= (phase + 1) % frame_len;
    frame_pulse_in <= (phase != 0);
    if (phase == 0) begin
      pcount <= pcount + 1;
    end
  end

  // first bit seen lands in bit 0
  always @(negedge serial_clock_in) begin
    if (serial_data_out_en === 1'h1) begin
      shreg = {serial_data_out, shreg[7:1]};
      nbit++;
      if (nbit == 8) begin
        cap_q.push_back(shreg);
        nbit = 0;
      end
    end else begin
      // each enable burst starts a new byte
      nbit = 0;
    end
  end

  task automatic set_tx(input logic v);
    @(posedge serial_clock_in);
    transmit_clock_enable_n <= v;
  endtask

  // data launched on rising edges, lsb first, while the receive enable is low
  task automatic send_bytes(input logic [7:0] b[$]);
    @(posedge serial_clock_in);
    receive_clock_enable_n <= 1'h0;
    repeat (2) @(posedge serial_clock_in);
    foreach (b[i]) begin
      for (int k = 0; k < 8; k++) begin
        serial_data_in <= b[i][k];
        @(posedge serial_clock_in);
      end
    end
    receive_clock_enable_n <= 1'h1;
    serial_data_in <= ~serial_data_in;
  endtask
endmodule

// file: tb/hsp_serial_port_tb.sv
// self-checking bench for the serial port timing and fifo status block
`include "hsp_consts.svh"
module hsp_serial_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hsp_pkg::*;
  localparam int DEPTH = `HSP_FIFO_DEPTH;
  logic clk;
  logic resetn;
  hsp_req_t req;
  logic [7:0] rdata;
  logic serial_clock_in;
  logic frame_pulse_in;
  logic transmit_clock_enable_n;
  logic receive_clock_enable_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_en;
  logic watchdog_out_n;
  int n_mismatch = 0;
  int cmp_count = 0;

  hsp_serial_port DUT (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .rdata(rdata),
    .serial_clock_in(serial_clock_in),
    .frame_pulse_in(frame_pulse_in),
    .transmit_clock_enable_n(transmit_clock_enable_n),
    .receive_clock_enable_n(receive_clock_enable_n),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en),
    .watchdog_out_n(watchdog_out_n)
  );

  hsp_link_model u_link (
    .serial_clock_in(serial_clock_in),
    .frame_pulse_in(frame_pulse_in),
    .transmit_clock_enable_n(transmit_clock_enable_n),
    .receive_clock_enable_n(receive_clock_enable_n),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] exp_status(input int rxn, input int txn);
    logic [1:0] rc;
    logic [1:0] tc;
    rc = (rxn == 0) ? 2'h0 : (rxn <= 14) ? 2'h1 : (rxn < DEPTH) ? 2'h3 : 2'h2;
    tc = (txn == 0) ? 2'h2 : (txn <= 4) ? 2'h3 : (txn < DEPTH) ? 2'h1 : 2'h0;
    return {2'h0, rc, tc, 2'h0};
  endfunction

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1;
    d = rdata;
  endtask

  // margin well past the delayed status refresh
  task automatic settle;
    repeat (60) @(posedge clk);
  endtask

  task automatic wait_pulses(input int target);
    while (u_link.pcount < target) begin
      @(posedge clk);
    end
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report;
  end

  initial begin
    logic [7:0] d;
    logic [7:0] txq[$];
    logic [7:0] rq[$];
    int p0;
    int sz;
    logic [7:0] cc;
    resetn = 1'h0;
    req = '0;
    void'($urandom(35));
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    chk_bit(watchdog_out_n, 1'h1);
    chk_bit(serial_data_out_en, 1'h0);
    settle;
    reg_rd(`HSP_OFF_FIFO_STATE, d);
    chk_byte(d, exp_status(0, 0));
    reg_rd(4'hF, d);
    chk_byte(d, 8'h00);
    reg_wr(`HSP_OFF_TIMING, 8'h00);
    reg_wr(`HSP_OFF_CONTROL, {4'h0, `HSP_FILL_TRANSPARENT, 2'h0});
    // fill the transmit fifo past full while the far side holds it off
    for (int i = 1; i <= DEPTH + 1; i++) begin
      d = 8'($urandom);
      if (i == DEPTH) begin
        d = 8'hA5;
      end
      reg_wr(`HSP_OFF_DATA, d);
      if (i <= DEPTH) begin
        txq.push_back(d);
      end
      reg_rd(`HSP_OFF_FIFO_STATE, d);
      chk_byte(d, exp_status(0, i - 1));
      settle;
      reg_rd(`HSP_OFF_FIFO_STATE, d);
      chk_byte(d, exp_status(0, (i > DEPTH) ? DEPTH : i));
    end
    u_link.set_tx(1'h0);
    for (int k = 0; k < 3000 && u_link.cap_q.size() < DEPTH + 4; k++) begin
      @(posedge clk);
    end
    u_link.set_tx(1'h1);
    // two idle bytes fill the shift and prefetch stages first
    chk_byte(u_link.cap_q[0], `HSP_IDLE_BYTE);
    chk_byte(u_link.cap_q[1], `HSP_IDLE_BYTE);
    for (int i = 0; i < DEPTH; i++) begin
      chk_byte(u_link.cap_q[i + 2], txq[i]);
    end
    chk_byte(u_link.cap_q[DEPTH + 2], txq[DEPTH - 1]);
    chk_byte(u_link.cap_q[DEPTH + 3], txq[DEPTH - 1]);
    settle;
    reg_rd(`HSP_OFF_FIFO_STATE, d);
    chk_byte(d, exp_status(0, 0));
    // one byte more than the receive fifo holds: the last one is dropped
    for (int i = 0; i <= DEPTH; i++) begin
      rq.push_back(8'($urandom));
    end
    rq[0] = 8'h01;
    u_link.send_bytes(rq);
    settle;
    for (int n = DEPTH; n >= 1; n--) begin
      reg_rd(`HSP_OFF_FIFO_STATE, d);
      chk_byte(d, exp_status(n, 0));
      reg_rd(`HSP_OFF_DATA, d);
      chk_byte(d, rq[DEPTH - n]);
      reg_rd(`HSP_OFF_FIFO_STATE, d);
      chk_byte(d, exp_status(n, 0));
      settle;
    end
    reg_rd(`HSP_OFF_FIFO_STATE, d);
    chk_byte(d, exp_status(0, 0));
    // internal mode, 2.048 MHz clock, control byte in channel 1, 8 bits in channel 2
    u_link.frame_len = 256;
    cc = 8'($urandom);
    reg_wr(`HSP_OFF_CC_TX, cc);
    reg_wr(`HSP_OFF_TIMING, 8'h70);
    u_link.cap_q.delete();
    repeat (2500) @(posedge clk);
    for (int k = 0; k < 1000 && serial_data_out_en !== 1'h0; k++) begin
      @(posedge clk);
    end
    sz = u_link.cap_q.size();
    chk_byte(u_link.cap_q[sz - 2], cc);
    chk_byte(u_link.cap_q[sz - 1], txq[DEPTH - 1]);
    reg_rd(`HSP_OFF_CC_STATUS, d);
    chk_byte(d, {8{serial_data_in}});
    reg_wr(`HSP_OFF_TIMING, 8'h00);
    u_link.frame_len = 4;
    // upper three bits are don't-care in the clear pattern
    reg_wr(`HSP_OFF_WATCHDOG, 8'hEA);
    p0 = u_link.pcount;
    wait_pulses(p0 + 500);
    reg_wr(`HSP_OFF_WATCHDOG, 8'h0B);
    wait_pulses(p0 + 1000);
    chk_bit(watchdog_out_n, 1'h1);
    wait_pulses(p0 + 1030);
    chk_bit(watchdog_out_n, 1'h0);
    reg_wr(`HSP_OFF_WATCHDOG, 8'h0A);
    p0 = u_link.pcount;
    wait_pulses(p0 + 4);
    chk_bit(watchdog_out_n, 1'h1);
    wait_pulses(p0 + 1030);
    chk_bit(watchdog_out_n, 1'h0);
    wait_pulses(p0 + 2040);
    chk_bit(watchdog_out_n, 1'h0);
    wait_pulses(p0 + 2060);
    chk_bit(watchdog_out_n, 1'h1);
    final_report;
  end
endmodule
